/* File: rtl/rcd_top.sv */
// Reference clock output block: bus registers, cycle clock and pin drive
`timescale 1ns/100ps
`include "rcd_regs.svh"
module rcd_top
  import rcd_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        reset,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  input  wire logic        sleep_active,
  input  wire logic        xtal_mode_select,
  input  wire logic        cycle_clock_output_config,
  input  wire logic        ref_pin_in,
  output logic             ref_pin_out,
  output logic             ref_pin_oe_n,
  output logic             ref_pin_slew_limit,
  output logic             ref_pin_clk_bypass
);

  rcd_gen_if gif ();

  // Control register and bus answer
  rcd_bus_state_t bus_state_ff;
  rcd_bus_state_t nxt_bus_state;
  rcd_byte_t      ctrl_ff;
  rcd_byte_t      nxt_ctrl;
  logic           ack_ff;
  logic           nxt_ack;
  logic [31:0]    dat_ff;
  logic [31:0]    nxt_dat;
  rcd_byte_t      status;

  // Pin group and cycle clock
  logic [1:0]     cyc_cnt_ff;
  logic [1:0]     nxt_cyc_cnt;
  rcd_pin_mode_t  mode_ff;
  rcd_pin_mode_t  nxt_mode;
  logic           out_ff;
  logic           nxt_out;
  logic           oe_n_ff;
  logic           nxt_oe_n;
  logic           slew_ff;
  logic           nxt_slew;
  logic           bypass_ff;
  logic           nxt_bypass;

  // Control fields to the divider and selector
  assign gif.enable    = ctrl_ff[`RCD_EN_BIT];
  assign gif.oe_bit    = ctrl_ff[`RCD_OE_BIT];
  assign gif.slr_bit   = ctrl_ff[`RCD_SLR_BIT];
  assign gif.duty      = ctrl_ff[`RCD_DC_HI:`RCD_DC_LO];
  assign gif.div       = ctrl_ff[`RCD_DIV_HI:`RCD_DIV_LO];
  assign gif.sleep     = sleep_active;
  assign gif.xtal_mode = xtal_mode_select;
  assign gif.cyc_cfg   = cycle_clock_output_config;
  assign gif.cyc_level = {30'h0, cyc_cnt_ff} < `RCD_CYC_HIGH;

  rcd_refgen u_refgen (
    .clk   (clk),
    .reset (reset),
    .gen   (gif.gen)
  );

  rcd_pinsel u_pinsel (
    .sel (gif.mux)
  );

  always_comb begin
    status                  = 8'h00;
    status[`RCD_ST_RUN_BIT] = gif.enable && !sleep_active;
    status[`RCD_ST_LVL_BIT] = gif.ref_level;
    status[`RCD_ST_REF_BIT] = (mode_ff == RCD_PIN_REF);
    status[`RCD_ST_CYC_BIT] = (mode_ff == RCD_PIN_CYCLE);
    status[`RCD_ST_OSC_BIT] = (mode_ff == RCD_PIN_OSC);
    status[`RCD_ST_SLP_BIT] = sleep_active;
    status[`RCD_ST_PIN_BIT] = ref_pin_in;
  end

  // Classic single-cycle slave: ack one cycle after the strobe, then one idle
  always_comb begin
    nxt_bus_state = bus_state_ff;
    nxt_ctrl      = ctrl_ff;
    nxt_ack       = 1'b0;
    nxt_dat       = dat_ff;
    case (bus_state_ff)
      RCD_BUS_IDLE: begin
        if (wb_cyc_i && wb_stb_i) begin
          nxt_bus_state = RCD_BUS_ACK;
          nxt_ack       = 1'b1;
          nxt_dat       = 32'h0000_0000;
          if (wb_adr_i == `RCD_CTRL_OFS) begin
            nxt_dat = {24'h00_0000, ctrl_ff};
          end else if (wb_adr_i == `RCD_STAT_OFS) begin
            nxt_dat = {24'h00_0000, status};
          end
        end
      end
      RCD_BUS_ACK: begin
        nxt_bus_state = RCD_BUS_IDLE;
        // Write lands on the edge the master sees ack; an abandoned cycle writes nothing
        if (wb_cyc_i && wb_stb_i && wb_we_i && wb_sel_i[0] && wb_adr_i == `RCD_CTRL_OFS) begin
          nxt_ctrl = wb_dat_i[7:0];
        end
      end
      default: begin
        nxt_bus_state = RCD_BUS_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      bus_state_ff <= RCD_BUS_IDLE;
      ctrl_ff      <= `RCD_CTRL_RST;
      ack_ff       <= 1'b0;
      dat_ff       <= 32'h0000_0000;
    end else begin
      bus_state_ff <= nxt_bus_state;
      ctrl_ff      <= nxt_ctrl;
      ack_ff       <= nxt_ack;
      dat_ff       <= nxt_dat;
    end
  end

  // Pin group freezes in Sleep; the bus registers keep running and answering then
  always_comb begin
    nxt_cyc_cnt = cyc_cnt_ff;
    nxt_mode    = mode_ff;
    nxt_out     = out_ff;
    nxt_oe_n    = oe_n_ff;
    nxt_slew    = slew_ff;
    nxt_bypass  = bypass_ff;
    if (!sleep_active) begin
      nxt_cyc_cnt = cyc_cnt_ff + 2'h1;
      nxt_mode    = gif.nxt_mode;
      nxt_out     = gif.nxt_out;
      nxt_oe_n    = gif.nxt_oe_n;
      nxt_slew    = gif.nxt_slew;
      nxt_bypass  = gif.nxt_bypass;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      cyc_cnt_ff <= 2'h0;
      mode_ff    <= RCD_PIN_IDLE;
      out_ff     <= 1'b0;
      oe_n_ff    <= 1'b1;
      slew_ff    <= 1'b0;
      bypass_ff  <= 1'b0;
    end else begin
      cyc_cnt_ff <= nxt_cyc_cnt;
      mode_ff    <= nxt_mode;
      out_ff     <= nxt_out;
      oe_n_ff    <= nxt_oe_n;
      slew_ff    <= nxt_slew;
      bypass_ff  <= nxt_bypass;
    end
  end

  assign wb_dat_o           = dat_ff;
  assign wb_ack_o           = ack_ff;
  assign ref_pin_out        = out_ff;
  assign ref_pin_oe_n       = oe_n_ff;
  assign ref_pin_slew_limit = slew_ff;
  // Pad gates clk with ref_pin_out when set, so divide-by-1 keeps source duty
  assign ref_pin_clk_bypass = bypass_ff;

endmodule : rcd_top

/* File: rtl/rcd_regs.svh */
// Register offsets, field positions, reset value and timing counts of the reference clock block
`ifndef RCD_REGS_SVH
`define RCD_REGS_SVH

`define RCD_CTRL_OFS     8'h00
`define RCD_STAT_OFS     8'h04

`define RCD_EN_BIT       7
`define RCD_OE_BIT       6
`define RCD_SLR_BIT      5
`define RCD_DC_HI        4
`define RCD_DC_LO        3
`define RCD_DIV_HI       2
`define RCD_DIV_LO       0
`define RCD_CTRL_RST     8'h30

`define RCD_ST_RUN_BIT   0
`define RCD_ST_LVL_BIT   1
`define RCD_ST_REF_BIT   2
`define RCD_ST_CYC_BIT   3
`define RCD_ST_OSC_BIT   4
`define RCD_ST_SLP_BIT   5
`define RCD_ST_PIN_BIT   6

`define RCD_CYC_DIV      4
`define RCD_CYC_HIGH     2

`endif

/* File: rtl/rcd_pkg.sv */
// Types and shared arithmetic of the reference clock block
package rcd_pkg;

  typedef logic [7:0] rcd_byte_t;

  typedef enum logic [1:0] {
    RCD_BUS_IDLE = 2'b01,
    RCD_BUS_ACK  = 2'b10
  } rcd_bus_state_t;

  typedef enum logic [3:0] {
    RCD_PIN_IDLE  = 4'b0001,
    RCD_PIN_OSC   = 4'b0010,
    RCD_PIN_CYCLE = 4'b0100,
    RCD_PIN_REF   = 4'b1000
  } rcd_pin_mode_t;

  // Division ratio 1..128 from the three-bit selector
  function automatic rcd_byte_t rcd_div_count(input logic [2:0] sel);
    rcd_div_count = 8'h01 << sel;
  endfunction : rcd_div_count

  // Cycles high per period; a nonzero duty never collapses to zero
  function automatic rcd_byte_t rcd_high_count(input logic [2:0] sel, input logic [1:0] dc);
    logic [9:0] prod;
    prod = {2'b00, rcd_div_count(sel)} * {8'h00, dc};
    rcd_high_count = prod[9:2];
    if (dc != 2'b00 && prod[9:2] == 8'h00) begin
      rcd_high_count = 8'h01;
    end
  endfunction : rcd_high_count

endpackage : rcd_pkg

/* File: rtl/rcd_gen_if.sv */
// Carrier between the control top, the divider and the pin selector
`timescale 1ns/100ps
interface rcd_gen_if;
  import rcd_pkg::*;
  logic          enable;
  logic          sleep;
  logic [1:0]    duty;
  logic [2:0]    div;
  logic          ref_level;
  logic          xtal_mode;
  logic          cyc_cfg;
  logic          oe_bit;
  logic          slr_bit;
  logic          cyc_level;
  rcd_pin_mode_t nxt_mode;
  logic          nxt_out;
  logic          nxt_oe_n;
  logic          nxt_slew;
  logic          nxt_bypass;
  modport ctl (output enable, sleep, duty, div, xtal_mode, cyc_cfg, oe_bit, slr_bit, cyc_level,
               input ref_level, nxt_mode, nxt_out, nxt_oe_n, nxt_slew, nxt_bypass);
  modport gen (input enable, sleep, duty, div, output ref_level);
  modport mux (input enable, div, ref_level, xtal_mode, cyc_cfg, oe_bit, slr_bit, cyc_level,
               output nxt_mode, nxt_out, nxt_oe_n, nxt_slew, nxt_bypass);
endinterface : rcd_gen_if

/* File: rtl/rcd_refgen.sv */
// Power-of-two divider with selectable duty cycle
`timescale 1ns/100ps
module rcd_refgen
  import rcd_pkg::*;
(
  input wire logic clk,
  input wire logic reset,
  rcd_gen_if.gen   gen
);

  logic [6:0] cnt_ff;
  logic [6:0] nxt_cnt;
  logic       lvl_ff;
  logic       nxt_lvl;
  rcd_byte_t  last;

  always_comb begin
    last    = rcd_div_count(gen.div) - 8'h01;
    nxt_cnt = cnt_ff;
    nxt_lvl = lvl_ff;
    if (!gen.enable) begin
      nxt_cnt = 7'h00;
      nxt_lvl = 1'b0;
    end else if (!gen.sleep) begin
      // Wrap also when a smaller ratio is written mid-period
      nxt_cnt = ({1'b0, cnt_ff} >= last) ? 7'h00 : cnt_ff + 7'h01;
      nxt_lvl = {1'b0, nxt_cnt} < rcd_high_count(gen.div, gen.duty);
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      cnt_ff <= 7'h00;
      lvl_ff <= 1'b0;
    end else begin
      cnt_ff <= nxt_cnt;
      lvl_ff <= nxt_lvl;
    end
  end

  assign gen.ref_level = lvl_ff;

endmodule : rcd_refgen

/* File: rtl/rcd_pinsel.sv */
// Priority selection of what the shared pin carries
`timescale 1ns/100ps
module rcd_pinsel
  import rcd_pkg::*;
(
  rcd_gen_if.mux sel
);

  always_comb begin
    sel.nxt_mode   = RCD_PIN_IDLE;
    sel.nxt_out    = 1'b0;
    sel.nxt_oe_n   = 1'b1;
    sel.nxt_slew   = 1'b0;
    sel.nxt_bypass = 1'b0;
    if (sel.xtal_mode) begin
      sel.nxt_mode = RCD_PIN_OSC;
    end else if (!sel.cyc_cfg) begin
      sel.nxt_mode = RCD_PIN_CYCLE;
      sel.nxt_out  = sel.cyc_level;
      sel.nxt_oe_n = 1'b0;
    end else if (sel.enable && sel.oe_bit) begin
      sel.nxt_mode   = RCD_PIN_REF;
      sel.nxt_out    = sel.ref_level;
      sel.nxt_oe_n   = 1'b0;
      sel.nxt_slew   = sel.slr_bit;
      sel.nxt_bypass = (sel.div == 3'b000);
    end
  end

endmodule : rcd_pinsel

/* File: tb/rcd_monitor.sv */
// Checker of the pin drive rules of the reference clock block
`timescale 1ns/100ps
module rcd_monitor (
  input wire logic        clk,
  input wire logic        reset,
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_we_i,
  input wire logic [7:0]  wb_adr_i,
  input wire logic [3:0]  wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic        wb_ack_o,
  input wire logic        sleep_active,
  input wire logic        xtal_mode_select,
  input wire logic        cycle_clock_output_config,
  input wire logic        ref_pin_out,
  input wire logic        ref_pin_oe_n,
  input wire logic        ref_pin_slew_limit,
  input wire logic        ref_pin_clk_bypass
);
  logic [7:0] ctl_ff;
  logic [7:0] nxt_ctl;
  logic       quiet;
  logic       refsel;
  // Shadow of the control register, loaded at the edge the master sees ack
  always_comb begin
    nxt_ctl = ctl_ff;
    if (wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o && wb_adr_i == 8'h00 && wb_sel_i[0]) begin
      nxt_ctl = wb_dat_i[7:0];
    end
  end
  always_ff @(posedge clk) begin
    ctl_ff <= reset ? 8'h30 : nxt_ctl;
  end
  assign quiet  = !xtal_mode_select && !sleep_active;
  assign refsel = quiet && cycle_clock_output_config;
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  property p_xtal; xtal_mode_select && !sleep_active |=> ref_pin_oe_n; endproperty
  a_xtal: assert property (p_xtal) else $error("pin driven in crystal mode");
  property p_cyc; (quiet && !cycle_clock_output_config)[*6] |-> !ref_pin_oe_n && !ref_pin_clk_bypass
    && ref_pin_out != $past(ref_pin_out, 2); endproperty
  a_cyc: assert property (p_cyc) else $error("pin not clk/4 with cycle clock");
  property p_drive; (refsel && ctl_ff[7:6] == 2'b11)[*2] |=> !ref_pin_oe_n; endproperty
  a_drive: assert property (p_drive) else $error("reference not driven");
  property p_idle; (refsel && ctl_ff[7:6] != 2'b11)[*2] |=> ref_pin_oe_n; endproperty
  a_idle: assert property (p_idle) else $error("pin driven while off");
  property p_slew; (refsel && ctl_ff[7:6] == 2'b11)[*2] |=> ref_pin_slew_limit == $past(ctl_ff[5]); endproperty
  a_slew: assert property (p_slew) else $error("slew limit wrong");
  property p_byp; (refsel && ctl_ff[7:6] == 2'b11 && ctl_ff[4:3] != 2'b00 && ctl_ff[2:0] == 3'h0)[*2]
    |=> ref_pin_clk_bypass && ref_pin_out; endproperty
  a_byp: assert property (p_byp) else $error("undivided output wrong");
  property p_sleep; sleep_active |=> $stable({ref_pin_out, ref_pin_oe_n, ref_pin_slew_limit, ref_pin_clk_bypass});
  endproperty
  a_sleep: assert property (p_sleep) else $error("pin moved in sleep");
  // Reset itself is the cause here, so this one is never disabled
  property p_rst; disable iff (1'b0) reset |=> ref_pin_oe_n && !ref_pin_out && !ref_pin_slew_limit
    && !ref_pin_clk_bypass && !wb_ack_o; endproperty
  a_rst: assert property (p_rst) else $error("outputs not cleared by reset");
endmodule : rcd_monitor
bind rcd_top rcd_monitor i_rcd_monitor (.clk, .reset, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i,
  .wb_dat_i, .wb_ack_o, .sleep_active, .xtal_mode_select, .cycle_clock_output_config, .ref_pin_out,
  .ref_pin_oe_n, .ref_pin_slew_limit, .ref_pin_clk_bypass);

/* File: tb/rcd_ext_dev.sv */
// External device sampling the pin on clk: measures period and high time
`timescale 1ns/100ps
module rcd_ext_dev (
  input wire logic  clk,
  input wire logic  pin_level,
  output logic [8:0] high_cnt,
  output logic [8:0] period_cnt
);
  logic       prev_ff = 1'b1;
  logic [8:0] run_ff  = 9'h000;
  logic [8:0] hi_ff   = 9'h000;
  // Figures are latched at each rising edge, so they describe the last whole period
  always_ff @(posedge clk) begin
    prev_ff <= pin_level;
    if (pin_level && !prev_ff) begin
      period_cnt <= run_ff;
      high_cnt   <= hi_ff;
      run_ff     <= 9'h001;
      hi_ff      <= 9'h001;
    end else begin
      run_ff <= run_ff + 9'h001;
      hi_ff  <= hi_ff + {8'h00, pin_level};
    end
  end
endmodule : rcd_ext_dev

/* File: tb/rcd_top_tb.sv */
// Bench for the reference clock block driving a measuring partner
`timescale 1ns/100ps
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin mismatches++; $display("Error %s exp %0h got %0h", nm, e, g); end end
module rcd_top_tb;
  logic        clk, reset, cyc, stb, we, slp, xtal, cfg, pin, last_ff, ack, pout, oe_n, slew, byp, s;
  logic [7:0]  adr, v;
  logic [3:0]  sel;
  logic [31:0] wdat, rdat, rd;
  logic [8:0]  hi, per;
  int          mismatches, n_tests, cyc_cnt;
  // A released pin has no pull, so it is made to wander
  assign pin = !oe_n ? pout : !last_ff;
  rcd_top i_rcd_top (.clk, .reset, .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
    .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .sleep_active(slp), .xtal_mode_select(xtal),
    .cycle_clock_output_config(cfg), .ref_pin_in(pin), .ref_pin_out(pout), .ref_pin_oe_n(oe_n),
    .ref_pin_slew_limit(slew), .ref_pin_clk_bypass(byp));
  rcd_ext_dev i_rcd_ext_dev (.clk, .pin_level(pin), .high_cnt(hi), .period_cnt(per));
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  always @(posedge clk) begin
    last_ff <= pin;
    cyc_cnt++;
    if (cyc_cnt == 20000) begin
      mismatches++;
      print_verdict();
    end
  end
  task automatic print_verdict();
    $display("tests %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : print_verdict
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [3:0] m);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    sel <= m;
    // Ends on ack; if ack never comes, only the run timeout ends this wait
    do @(posedge clk); while (ack !== 1'b1);
    rd = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk);
    `CHK("ack_drop", 1'b0, ack)
  endtask : wb
  initial begin
    int p, h;
    {cyc, stb, we, slp, xtal, last_ff} = '0;
    {cfg, reset} = 2'b11;
    {adr, sel, wdat} = '0;
    repeat (10) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    `CHK("oe_n", 1'b1, oe_n)
    wb(1'b0, 8'h00, 32'h0, 4'hf);
    `CHK("ctrl", 32'h30, rd)
    wb(1'b1, 8'h08, 32'hff, 4'hf);
    wb(1'b0, 8'h08, 32'h0, 4'hf);
    `CHK("unmapped", 32'h0, rd)
    wb(1'b1, 8'h00, 32'hff, 4'he);
    wb(1'b0, 8'h00, 32'h0, 4'hf);
    `CHK("ctrl_kept", 32'h30, rd)
    $display("test reset and map done");
    for (int d = 1; d < 8; d++) begin
      for (int c = 1; c < 4; c++) begin
        p = 1 << d;
        h = (p * c / 4 == 0) ? 1 : p * c / 4;
        v = {2'b10, d[0], c[1:0], d[2:0]};
        wb(1'b1, 8'h00, {24'h0, v}, 4'hf);
        wb(1'b1, 8'h00, {24'h0, v | 8'h40}, 4'hf);
        repeat (3 * p + 6) @(posedge clk);
        `CHK("period", p[8:0], per)
        `CHK("high", h[8:0], hi)
        `CHK("slew", d[0], slew)
        `CHK("nobypass", 1'b0, byp)
      end
    end
    $display("test divider and duty done");
    wb(1'b1, 8'h00, 32'hc1, 4'hf);
    repeat (6) @(posedge clk);
    repeat (4) begin
      @(posedge clk);
      `CHK("duty0", 1'b0, pout)
    end
    wb(1'b1, 8'h00, 32'hd8, 4'hf);
    repeat (4) @(posedge clk);
    `CHK("bypass", 1'b1, byp)
    wb(1'b1, 8'h00, 32'hd3, 4'hf);
    repeat (5) @(posedge clk);
    slp <= 1'b1;
    repeat (2) @(posedge clk);
    s = pout;
    repeat (16) begin
      @(posedge clk);
      `CHK("sleep", s, pout)
    end
    wb(1'b0, 8'h04, 32'h0, 4'hf);
    `CHK("st_sleep", 8'h24, rd[7:0] & 8'h3d)
    slp <= 1'b0;
    xtal <= 1'b1;
    repeat (3) @(posedge clk);
    `CHK("xtal", 1'b1, oe_n)
    wb(1'b0, 8'h04, 32'h0, 4'hf);
    `CHK("st_osc", 8'h11, rd[7:0] & 8'h3d)
    xtal <= 1'b0;
    cfg <= 1'b0;
    repeat (8) @(posedge clk);
    `CHK("cycclk", 1'b0, oe_n)
    wb(1'b0, 8'h04, 32'h0, 4'hf);
    `CHK("st_cyc", 8'h09, rd[7:0] & 8'h3d)
    cfg <= 1'b1;
    wb(1'b1, 8'h00, 32'h40, 4'hf);
    repeat (3) @(posedge clk);
    `CHK("off", 1'b1, oe_n)
    $display("test pin ownership done");
    reset <= 1'b1;
    repeat (2) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    wb(1'b0, 8'h00, 32'h0, 4'hf);
    `CHK("ctrl2", 32'h30, rd)
    $display("test second reset done");
    print_verdict();
  end
endmodule : rcd_top_tb
